// ===== verilog/sst_pkg.sv
/*
 * shared constants and types for the stop-state and subtract/transfer unit.
 * assumes an apb master with 32-bit data and one aligned word per register.
 */
package sst_pkg;
	// -------------------------------------------------------------
	// register offsets
	// -------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_IMM    = 8'h04;
	localparam logic [7:0] OFS_A_LO   = 8'h08;
	localparam logic [7:0] OFS_A_HI   = 8'h0c;
	localparam logic [7:0] OFS_B_LO   = 8'h10;
	localparam logic [7:0] OFS_B_HI   = 8'h14;
	localparam logic [7:0] OFS_X0     = 8'h18;
	localparam logic [7:0] OFS_X1     = 8'h1c;
	localparam logic [7:0] OFS_Y0     = 8'h20;
	localparam logic [7:0] OFS_Y1     = 8'h24;
	localparam logic [7:0] OFS_OMR    = 8'h28;
	localparam logic [7:0] OFS_CLOCK_CONTROL_REGISTER   = 8'h2c;
	localparam logic [7:0] OFS_STATUS = 8'h30;
	localparam logic [7:0] OFS_R_BASE = 8'h40;
	// -------------------------------------------------------------
	// field positions and reset values
	// -------------------------------------------------------------
	localparam int OMR_SD_BIT    = 6;
	localparam int CLOCK_CONTROL_REGISTER_STOP_PROCESSING_STATE_BIT_BIT = 5;
	localparam int CCR_C = 0;
	localparam int CCR_V = 1;
	localparam int CCR_Z = 2;
	localparam int CCR_N = 3;
	localparam int STAT_STOP  = 8;
	localparam int STAT_DELAY = 9;
	localparam logic [23:0] RST_WORD = 24'h000000;
	localparam logic [55:0] RST_ACC  = 56'h00000000000000;
	localparam logic [7:0]  RST_CCR  = 8'h00;
	// -------------------------------------------------------------
	// operation codes
	// -------------------------------------------------------------
	localparam logic [3:0] OP_NOP  = 4'h0;
	localparam logic [3:0] OP_SUB  = 4'h1;
	localparam logic [3:0] OP_SHIFT_LEFT_SUBTRACT_OP = 4'h2;
	localparam logic [3:0] OP_SHIFT_RIGHT_SUBTRACT_OP = 4'h3;
	localparam logic [3:0] OP_TCC  = 4'h4;
	localparam logic [3:0] OP_TFR  = 4'h5;
	localparam logic [3:0] OP_STOP = 4'h6;
	// source select: 0 other acc, 1 x long, 2 y long, 3 x0, 4 y0,
	// 5 x1, 6 y1, 7 immediate
	localparam logic [2:0] SRC_ACC = 3'h0;
	localparam logic [2:0] SRC_IMM = 3'h7;
	// -------------------------------------------------------------
	// wake delay counts
	// -------------------------------------------------------------
	localparam int          STOP_LONG_CYC   = 131070;
	localparam int          STOP_SD_CYC_I   = 24;
	localparam int          STOP_PROCESSING_STATE_BIT_HALF_CYC   = 17; // 8.5 cycles in halves
	localparam logic [16:0] STOP_SD_CYC     = 17'(STOP_SD_CYC_I);
	localparam logic [16:0] STOP_STOP_PROCESSING_STATE_BIT_CYC   = 17'((STOP_PROCESSING_STATE_BIT_HALF_CYC + 1) / 2);

	typedef struct packed {
		logic [13:0] rsvd;
		logic        pmove;
		logic [2:0]  dst_r;
		logic [2:0]  src_r;
		logic        move_r;
		logic        cond;
		logic        long_imm;
		logic [2:0]  src;
		logic        dsel;
		logic [3:0]  op;
	} sst_cmd_t;

	typedef struct packed {
		logic        ctrl_active;
		logic        data_oe;
		logic [23:0] addr;
	} sst_port_t;

	typedef enum logic [1:0] { ST_RUN, ST_STOPPED, ST_DELAY } sst_state_t;
endpackage : sst_pkg

// ===== verilog/sst_core.sv
/*
 * stop-state controller and subtract/transfer execution unit with apb regs.
 * assumes pins are synchronous to pclk and an apb master on the bus.
 */
`timescale 1ns/10ps
`default_nettype none
module sst_core import sst_pkg::*; #(
	parameter int STOP_LONG = STOP_LONG_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata_q,
	output logic             pready_q,
	output logic             pslverr_q,
	input  wire logic        ext_reset_n,
	input  wire logic        interrupt_request_a_pin,
	input  wire logic        jtag_debug_req,
	input  wire logic        int_pending,
	input  wire sst_port_t   core_port,
	output sst_port_t        port_q,
	output logic             core_clk_en_q,
	output logic             periph_clear_q,
	output logic             wake_reset_q,
	output logic             wake_irq_q,
	output logic             wake_resume_q
);
	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	sst_state_t  st_q, st_d;
	logic [16:0] cnt_q, cnt_d;
	logic        cause_irq_q, cause_irq_d;
	logic [55:0] a_q, b_q;
	logic [23:0] x0_q, x1_q, y0_q, y1_q, imm_q;
	logic [23:0] r_q [8];
	logic [7:0]  operating_mode_register, clock_control_register;
	logic [7:0]  ccr_q;

	// -------------------------------------------------------------
	// apb decode
	// -------------------------------------------------------------
	wire       access  = psel & penable;
	wire       wr_en   = access & pready_q & pwrite;
	wire       r_hit   = (paddr[7:5] == OFS_R_BASE[7:5]) & (paddr[1:0] == 2'h0);
	wire [2:0] r_idx   = paddr[4:2];
	wire       ctl_wr  = wr_en & (paddr == OFS_CTRL);
	sst_cmd_t  cmd;
	assign cmd = pwdata;
	// ops only run while the core clock is live
	wire       exec    = ctl_wr & (st_q == ST_RUN);
	wire       is_sub  = (cmd.op == OP_SUB);
	wire       is_shift_left_subtract_op = (cmd.op == OP_SHIFT_LEFT_SUBTRACT_OP);
	wire       is_shift_right_subtract_op = (cmd.op == OP_SHIFT_RIGHT_SUBTRACT_OP);
	wire       sub_any = exec & (is_sub | is_shift_left_subtract_op | is_shift_right_subtract_op);
	wire       do_tcc  = exec & (cmd.op == OP_TCC) & cmd.cond;
	wire       do_tfr  = exec & (cmd.op == OP_TFR);
	wire       do_stop = exec & (cmd.op == OP_STOP);
	wire       stop_delay_select_bit = operating_mode_register[OMR_SD_BIT];
	wire       stop_processing_state_bit =
		clock_control_register[CLOCK_CONTROL_REGISTER_STOP_PROCESSING_STATE_BIT_BIT];

	// -------------------------------------------------------------
	// operand selection and alu
	// -------------------------------------------------------------
	wire [55:0] acc_dst = cmd.dsel ? b_q : a_q;
	wire [55:0] acc_oth = cmd.dsel ? a_q : b_q;
	logic [55:0] src_val;
	logic [23:0] word_v;
	always_comb begin
		word_v = imm_q;
		unique case (cmd.src)
			3'h3: word_v = x0_q;
			3'h4: word_v = y0_q;
			3'h5: word_v = x1_q;
			3'h6: word_v = y1_q;
			default: word_v = imm_q;
		endcase
		// words sit in bits 47:24, sign-extended into the extension
		src_val = {{8{word_v[23]}}, word_v, 24'h000000};
		unique case (cmd.src)
			SRC_ACC: src_val = acc_oth;
			3'h1:    src_val = {{8{x1_q[23]}}, x1_q, x0_q};
			3'h2:    src_val = {{8{y1_q[23]}}, y1_q, y0_q};
			SRC_IMM: if (!cmd.long_imm)
				src_val = {26'h0000000, imm_q[5:0], 24'h000000};
			default: ;
		endcase
	end

	// shift variants always take the other accumulator
	wire [55:0] sub_src = (is_shift_left_subtract_op | is_shift_right_subtract_op) ? acc_oth : src_val;
	wire [55:0] sub_in  = is_shift_left_subtract_op ? {acc_dst[54:0], 1'b0} :
		is_shift_right_subtract_op ? {acc_dst[55], acc_dst[55:1]} : acc_dst;
	// full 56-bit difference: carry exact when the extension is sane
	wire [56:0] diff    = {1'b0, sub_in} - {1'b0, sub_src};
	wire [55:0] res     = diff[55:0];
	wire        sub_v   = (sub_in[55] ^ sub_src[55]) & (res[55] ^ sub_in[55]);
	wire        shl_v   = is_shift_left_subtract_op & (acc_dst[55] ^ acc_dst[54]);
	logic [7:0] ccr_new;
	always_comb begin
		ccr_new        = ccr_q;
		ccr_new[CCR_C] = diff[56];
		ccr_new[CCR_V] = sub_v | shl_v;
		ccr_new[CCR_Z] = (res == 56'h00000000000000);
		ccr_new[CCR_N] = res[55];
	end
	wire [55:0] acc_wr  = sub_any ? res : src_val;
	wire        acc_we  = sub_any | do_tcc | do_tfr;

	// -------------------------------------------------------------
	// accumulators and condition codes
	// -------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_q   <= RST_ACC;
			b_q   <= RST_ACC;
			ccr_q <= RST_CCR;
		end else begin
			if (acc_we && !cmd.dsel)
				a_q <= acc_wr;
			else if (wr_en && paddr == OFS_A_LO)
				a_q[31:0] <= pwdata;
			else if (wr_en && paddr == OFS_A_HI)
				a_q[55:32] <= pwdata[23:0];
			if (acc_we && cmd.dsel)
				b_q <= acc_wr;
			else if (wr_en && paddr == OFS_B_LO)
				b_q[31:0] <= pwdata;
			else if (wr_en && paddr == OFS_B_HI)
				b_q[55:32] <= pwdata[23:0];
			// copies leave the flags alone
			if (sub_any)
				ccr_q <= ccr_new;
		end
	end

	// -------------------------------------------------------------
	// data, immediate and mode registers
	// -------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			x0_q <= RST_WORD;
			x1_q <= RST_WORD;
			y0_q <= RST_WORD;
			y1_q <= RST_WORD;
			imm_q <= RST_WORD;
			operating_mode_register <= 8'h00;
			clock_control_register  <= 8'h00;
		end else begin
			if (do_tfr && cmd.pmove)
				x0_q <= imm_q;
			else if (wr_en && paddr == OFS_X0)
				x0_q <= pwdata[23:0];
			if (wr_en && paddr == OFS_X1)
				x1_q <= pwdata[23:0];
			if (wr_en && paddr == OFS_Y0)
				y0_q <= pwdata[23:0];
			if (wr_en && paddr == OFS_Y1)
				y1_q <= pwdata[23:0];
			if (wr_en && paddr == OFS_IMM)
				imm_q <= pwdata[23:0];
			if (wr_en && paddr == OFS_OMR)
				operating_mode_register <= pwdata[7:0];
			if (wr_en && paddr == OFS_CLOCK_CONTROL_REGISTER)
				clock_control_register <= pwdata[7:0];
		end
	end

	// address registers: one slot per index
	for (genvar i = 0; i < 8; i++) begin : g_r
		wire sw_wr = wr_en & r_hit & (r_idx == 3'(i));
		wire hw_wr = do_tcc & cmd.move_r & (cmd.dst_r == 3'(i));
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				r_q[i] <= RST_WORD;
			else if (hw_wr)
				r_q[i] <= r_q[cmd.src_r];
			else if (sw_wr)
				r_q[i] <= pwdata[23:0];
		end
	end

	// -------------------------------------------------------------
	// stop state machine
	// -------------------------------------------------------------
	wire [16:0] dly_sel = stop_processing_state_bit ? STOP_STOP_PROCESSING_STATE_BIT_CYC :
		stop_delay_select_bit ? STOP_SD_CYC : 17'(STOP_LONG);
	wire        wake_src  = !interrupt_request_a_pin | jtag_debug_req;
	wire        dly_done  = (st_q == ST_DELAY) & (cnt_q == 17'h00001);
	wire        to_reset  = (st_q != ST_RUN) & !ext_reset_n;

	always_comb begin
		st_d        = st_q;
		cnt_d       = cnt_q;
		cause_irq_d = cause_irq_q;
		unique case (st_q)
			ST_RUN: if (do_stop) begin
				cnt_d       = dly_sel;
				cause_irq_d = !interrupt_request_a_pin;
				// request already low: skip the clock gate
				st_d = !interrupt_request_a_pin ? ST_DELAY : ST_STOPPED;
			end
			ST_STOPPED: if (!ext_reset_n)
				st_d = ST_RUN;
			else if (wake_src) begin
				st_d        = ST_DELAY;
				cause_irq_d = !interrupt_request_a_pin;
			end
			ST_DELAY: if (!ext_reset_n || dly_done)
				st_d = ST_RUN;
			else
				cnt_d = cnt_q - 17'h00001;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q        <= ST_RUN;
			cnt_q       <= 17'h00000;
			cause_irq_q <= 1'b0;
		end else begin
			st_q        <= st_d;
			cnt_q       <= cnt_d;
			cause_irq_q <= cause_irq_d;
		end
	end

	// -------------------------------------------------------------
	// pins and wake pulses
	// -------------------------------------------------------------
	wire fin_ok = dly_done & ext_reset_n;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_clk_en_q  <= 1'b1;
			periph_clear_q <= 1'b0;
			wake_reset_q   <= 1'b0;
			wake_irq_q     <= 1'b0;
			wake_resume_q  <= 1'b0;
			port_q         <= '0;
		end else begin
			core_clk_en_q  <= (st_d != ST_STOPPED);
			periph_clear_q <= (st_d == ST_DELAY);
			wake_reset_q   <= to_reset;
			wake_irq_q     <= fin_ok & cause_irq_q & int_pending;
			wake_resume_q  <= fin_ok & !(cause_irq_q & int_pending);
			if (st_d == ST_RUN)
				port_q <= core_port;
			else begin
				port_q.ctrl_active <= 1'b0;
				port_q.data_oe     <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------------
	// apb read path, one wait state
	// -------------------------------------------------------------
	logic [31:0] rd_data;
	logic        rd_hit;
	always_comb begin
		rd_hit  = 1'b1;
		rd_data = 32'h00000000;
		if (r_hit)
			rd_data = {8'h00, r_q[r_idx]};
		else unique case (paddr)
			OFS_CTRL:   rd_data = 32'h00000000;
			OFS_IMM:    rd_data = {8'h00, imm_q};
			OFS_A_LO:   rd_data = a_q[31:0];
			OFS_A_HI:   rd_data = {8'h00, a_q[55:32]};
			OFS_B_LO:   rd_data = b_q[31:0];
			OFS_B_HI:   rd_data = {8'h00, b_q[55:32]};
			OFS_X0:     rd_data = {8'h00, x0_q};
			OFS_X1:     rd_data = {8'h00, x1_q};
			OFS_Y0:     rd_data = {8'h00, y0_q};
			OFS_Y1:     rd_data = {8'h00, y1_q};
			OFS_OMR:    rd_data = {24'h000000, operating_mode_register};
			OFS_CLOCK_CONTROL_REGISTER:   rd_data = {24'h000000, clock_control_register};
			OFS_STATUS: begin
				rd_data             = {24'h000000, ccr_q};
				rd_data[STAT_STOP]  = (st_q == ST_STOPPED);
				rd_data[STAT_DELAY] = (st_q == ST_DELAY);
			end
			default:    rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= access & !pready_q;
			if (access && !pready_q) begin
				prdata_q  <= pwrite ? 32'h00000000 : rd_data;
				pslverr_q <= !rd_hit;
			end else
				pslverr_q <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	logic [16:0] dly_len_q, exp_len_q;
	logic [55:0] res_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_len_q <= 17'h00000;
			exp_len_q <= 17'h00000;
			res_q     <= RST_ACC;
		end else begin
			dly_len_q <= (st_q == ST_DELAY) ? dly_len_q + 17'h00001 : 17'h00000;
			if (do_stop)
				exp_len_q <= dly_sel;
			res_q <= res;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_stop_gates_clk: assert property (
		do_stop && interrupt_request_a_pin |=> !core_clk_en_q && st_q == ST_STOPPED)
		else $error("stop did not gate the clock");
	chk_stop_port_idle: assert property (
		st_q == ST_STOPPED && $past(st_q) == ST_STOPPED
		|-> !port_q.ctrl_active && !port_q.data_oe && $stable(port_q.addr))
		else $error("port not idle while stopped");
	chk_reset_wake: assert property (
		st_q == ST_STOPPED && !ext_reset_n |=> wake_reset_q && st_q == ST_RUN)
		else $error("reset pin did not start reset processing");
	chk_irq_service: assert property (
		fin_ok && cause_irq_q && int_pending |=> wake_irq_q && !wake_resume_q)
		else $error("pending interrupt not serviced at wake");
	chk_resume_next: assert property (
		fin_ok && !int_pending |=> wake_resume_q && !wake_irq_q)
		else $error("no resume after delay");
	chk_delay_length: assert property (
		fin_ok |-> dly_len_q == exp_len_q - 17'h00001)
		else $error("wake delay length wrong");
	chk_stop_processing_state_bit_delay: assert property (
		do_stop && stop_processing_state_bit && !interrupt_request_a_pin
		|=> ##8 st_q == ST_DELAY && cnt_q == 17'h00001)
		else $error("short stop delay not nine cycles");
	chk_periph_held: assert property (
		st_q == ST_DELAY && $past(st_q) == ST_DELAY |-> periph_clear_q)
		else $error("peripherals released during delay");
	chk_interrupt_request_a_pin_no_gate: assert property (
		do_stop && !interrupt_request_a_pin |=> core_clk_en_q && st_q == ST_DELAY)
		else $error("clock gated with request already low");
	chk_sub_result: assert property (
		sub_any && !cmd.dsel |=> a_q == $past(res))
		else $error("subtract result not written");
	chk_tcc_flags: assert property (
		exec && cmd.op == OP_TCC |=> $stable(ccr_q))
		else $error("conditional copy touched flags");

	cov_stop_irq_wake: cover property (
		st_q == ST_STOPPED ##1 st_q == ST_DELAY ##[1:40] wake_irq_q);
	cov_stop_reset: cover property (st_q == ST_STOPPED ##1 wake_reset_q);
	cov_shift_left_subtract_op_exec: cover property (sub_any && is_shift_left_subtract_op && shl_v);
	cov_tcc_move: cover property (do_tcc && cmd.move_r);
endmodule : sst_core
`default_nettype wire

// ===== test/sst_ext_model.sv
/*
 * far-side model for sst_core: request A pin, pending flag, reset pin,
 * debug request and a core port that never sits still.
 * assumes the bench asks for pin levels on rising edges of pclk.
 */
`timescale 1ns/10ps
`default_nettype none
module sst_ext_model import sst_pkg::*; (
	input  wire logic  pclk,
	input  wire logic  presetn,
	input  wire logic  req_a,
	input  wire logic  pend,
	input  wire logic  rst_req,
	input  wire logic  dbg,
	output logic       interrupt_request_a_pin,
	output logic       int_pending,
	output logic       ext_reset_n,
	output logic       jtag_debug_req,
	output sst_port_t  core_port
);
	// -------------------------------------------------------------
	// pins
	// -------------------------------------------------------------
	logic [23:0] cnt_q;
	// one stage of delay, as a pad synchroniser would add
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_request_a_pin <= 1'b1;
			int_pending             <= 1'b0;
			ext_reset_n             <= 1'b1;
			jtag_debug_req          <= 1'b0;
			cnt_q                   <= 24'h000000;
		end else begin
			interrupt_request_a_pin <= ~req_a;
			int_pending             <= pend;
			ext_reset_n             <= ~rst_req;
			jtag_debug_req          <= dbg;
			cnt_q                   <= cnt_q + 24'h000001;
		end
	end
	// address walks every cycle, so a held port is plainly visible
	assign core_port = '{ctrl_active: 1'b1, data_oe: 1'b1, addr: cnt_q};
endmodule : sst_ext_model
`default_nettype wire

// ===== test/tb.sv
/*
 * self-checking bench for sst_core: apb tasks, alu ops, stop and wake.
 * assumes sst_pkg and sst_ext_model are compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none
module tb import sst_pkg::*;;
	localparam int          LONG = 30;
	localparam logic [23:0] X0V  = 24'h123456;
	localparam logic [23:0] X1V  = 24'h800001;
	localparam logic [23:0] Y0V  = 24'hfedcba;
	localparam logic [23:0] Y1V  = 24'h000010;
	localparam logic [31:0] IMMV = 32'h00ffff85;
	localparam logic [55:0] A0   = 56'h00734567_89abcd;
	localparam logic [55:0] B0   = 56'h80000000_000000;
	localparam logic [55:0] A1   = 56'h40000000_000000;
	localparam logic [55:0] B1   = 56'h00000001_000000;
	localparam logic [55:0] A2   = 56'h00000000_000005;
	localparam logic [55:0] B2   = 56'hf0000000_000001;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata_q, rdv;
	logic        pready_q, pslverr_q, rerr;
	logic        ext_reset_n, interrupt_request_a_pin, jtag_debug_req;
	logic        int_pending, req_a, pend, rst_req, dbg;
	sst_port_t   core_port, port_q;
	logic        core_clk_en_q, periph_clear_q;
	logic        wake_reset_q, wake_irq_q, wake_resume_q;
	logic [55:0] av, bv;
	logic [59:0] ex;
	logic [3:0]  cc;
	logic [23:0] hold;
	sst_cmd_t    cmd;
	int          err_total, checked, k, i, n, cnt, kind;

	sst_core #(.STOP_LONG(LONG)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
		.pslverr_q(pslverr_q), .ext_reset_n(ext_reset_n),
		.interrupt_request_a_pin(interrupt_request_a_pin),
		.jtag_debug_req(jtag_debug_req), .int_pending(int_pending),
		.core_port(core_port), .port_q(port_q),
		.core_clk_en_q(core_clk_en_q), .periph_clear_q(periph_clear_q),
		.wake_reset_q(wake_reset_q), .wake_irq_q(wake_irq_q),
		.wake_resume_q(wake_resume_q));
	sst_ext_model i_ext (.pclk(pclk), .presetn(presetn), .req_a(req_a),
		.pend(pend), .rst_req(rst_req), .dbg(dbg),
		.interrupt_request_a_pin(interrupt_request_a_pin),
		.int_pending(int_pending), .ext_reset_n(ext_reset_n),
		.jtag_debug_req(jtag_debug_req), .core_port(core_port));

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [55:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one idle cycle between transfers keeps every signal single-driven
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready_q !== 1'b1 && t < 20);
		if (t >= 20) begin
			err_total++;
			conclude();
		end
		rdv = prdata_q;
		rerr = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic put(input logic [7:0] a, input logic [55:0] v);
		apb(1'b1, a, v[31:0]);
		apb(1'b1, a + 8'h04, {8'h00, v[55:32]});
	endtask : put

	task automatic get(input logic [7:0] a, output logic [55:0] v);
		apb(1'b0, a, 32'h0);
		v[31:0] = rdv;
		apb(1'b0, a + 8'h04, 32'h0);
		v[55:32] = rdv[23:0];
	endtask : get

	task automatic run(input logic [55:0] a0, b0, xa, xb,
		input logic [3:0] xc);
		put(OFS_A_LO, a0);
		put(OFS_B_LO, b0);
		apb(1'b1, OFS_CTRL, cmd);
		get(OFS_A_LO, av);
		chk("acc_a", av, xa);
		get(OFS_B_LO, bv);
		chk("acc_b", bv, xb);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("ccr", rdv[3:0], xc);
	endtask : run

	function automatic logic [55:0] sx(input logic [23:0] w);
		return {{8{w[23]}}, w, 24'h000000};
	endfunction : sx

	function automatic logic [55:0] srcv(input int s);
		case (s)
			0: return B0;
			1: return {{8{X1V[23]}}, X1V, X0V};
			2: return {{8{Y1V[23]}}, Y1V, Y0V};
			3: return sx(X0V);
			4: return sx(Y0V);
			5: return sx(X1V);
			6: return sx(Y1V);
			7: return {26'h0, IMMV[5:0], 24'h000000};
			default: return sx(IMMV[23:0]);
		endcase
	endfunction : srcv

	// flags packed as n z v c, borrow as carry
	function automatic logic [59:0] sub56(input logic [55:0] d, s,
		input logic vx);
		logic [56:0] t;
		t = {1'b0, d} - {1'b0, s};
		return {t[55], t[55:0] == 56'h0,
			((d[55] ^ s[55]) & (t[55] ^ d[55])) | vx, t[56], t[55:0]};
	endfunction : sub56

	// -------------------------------------------------------------
	// sequence
	// -------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	initial begin
		{presetn, psel, penable, pwrite, req_a, pend, rst_req, dbg} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		err_total = 0;
		checked = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		get(OFS_A_LO, av);
		chk("acc_rst", av, RST_ACC);
		apb(1'b0, 8'h3c, 32'h0);
		chk("slverr", rerr, 1'b1);
		chk("unmapped", rdv, 32'h0);
		$display("test reset and decode done");
		apb(1'b1, OFS_X0, {8'h00, X0V});
		apb(1'b1, OFS_X1, {8'h00, X1V});
		apb(1'b1, OFS_Y0, {8'h00, Y0V});
		apb(1'b1, OFS_Y1, {8'h00, Y1V});
		apb(1'b1, OFS_IMM, IMMV);
		for (k = 0; k < 9; k++) begin
			cmd = '0;
			cmd.op = OP_SUB;
			cmd.src = (k > 7) ? SRC_IMM : 3'(k);
			cmd.long_imm = (k == 8);
			ex = sub56(A0, srcv(k), 1'b0);
			run(A0, B0, ex[55:0], B0, ex[59:56]);
		end
		$display("test subtract sources done");
		cmd = '0;
		cmd.op = OP_SHIFT_LEFT_SUBTRACT_OP;
		cmd.src = 3'h3;
		ex = sub56({A1[54:0], 1'b0}, B1, A1[55] ^ A1[54]);
		run(A1, B1, ex[55:0], B1, ex[59:56]);
		cmd.op = OP_SHIFT_RIGHT_SUBTRACT_OP;
		cmd.dsel = 1'b1;
		cmd.src = 3'h5;
		ex = sub56({B2[55], B2[55:1]}, A2, 1'b0);
		cc = ex[59:56];
		run(A2, B2, A2, ex[55:0], cc);
		$display("test shift subtract done");
		apb(1'b1, OFS_R_BASE + 8'h08, 32'h00000abc);
		cmd = '0;
		cmd.op = OP_TCC;
		cmd.dsel = 1'b1;
		cmd.src = 3'h3;
		cmd.cond = 1'b1;
		cmd.move_r = 1'b1;
		cmd.src_r = 3'h2;
		cmd.dst_r = 3'h5;
		run(A2, B2, A2, sx(X0V), cc);
		apb(1'b0, OFS_R_BASE + 8'h14, 32'h0);
		chk("r5", rdv, 32'h00000abc);
		cmd.cond = 1'b0;
		cmd.dst_r = 3'h6;
		run(A2, B2, A2, B2, cc);
		apb(1'b0, OFS_R_BASE + 8'h18, 32'h0);
		chk("r6", rdv, 32'h0);
		cmd = '0;
		cmd.op = OP_TFR;
		cmd.pmove = 1'b1;
		run(A2, B2, B2, B2, cc);
		apb(1'b0, OFS_X0, 32'h0);
		chk("x0_move", rdv[23:0], IMMV[23:0]);
		$display("test transfers done");
		// case 4 repeats case 0 after a long count and a reset wake
		for (i = 0; i < 5; i++) begin
			k = i % 4;
			apb(1'b1, OFS_OMR, (k != 2) ? 32'h00000040 : 32'h0);
			apb(1'b1, OFS_CLOCK_CONTROL_REGISTER, (k == 1) ? 32'h00000020 : 32'h0);
			pend <= (k == 0);
			req_a <= (k == 1);
			cmd = '0;
			cmd.op = OP_STOP;
			apb(1'b1, OFS_CTRL, cmd);
			cnt = 0;
			kind = 0;
			// a stop with request A already low starts the delay at once
			#1;
			if (periph_clear_q === 1'b1) cnt++;
			for (n = 0; n < 300 && kind == 0; n++) begin
				@(posedge pclk);
				if (n == 8 && k == 0) req_a <= 1'b1;
				if (n == 8 && k == 2) dbg <= 1'b1;
				if (n == 8 && k == 3) rst_req <= 1'b1;
				#1;
				if (periph_clear_q === 1'b1) cnt++;
				if (wake_reset_q === 1'b1) kind = 1;
				if (wake_irq_q === 1'b1) kind = 2;
				if (wake_resume_q === 1'b1) kind = 3;
				if (n == 4 && k != 1) begin
					hold = port_q.addr;
					chk("clk_gated", core_clk_en_q, 1'b0);
					chk("port_idle", {port_q.ctrl_active, port_q.data_oe}, 2'b00);
				end
				if (n == 7 && k != 1) chk("addr_held", port_q.addr, hold);
				if (n == 2 && k == 1) chk("clk_kept", core_clk_en_q, 1'b1);
			end
			chk("delay", cnt, (k == 0) ? STOP_SD_CYC_I : (k == 1) ?
				(STOP_PROCESSING_STATE_BIT_HALF_CYC + 1) / 2 : (k == 2) ? LONG : 0);
			chk("wake_kind", kind, (k == 0) ? 2 : (k == 3) ? 1 : 3);
			if (kind == 0) conclude();
			@(posedge pclk);
			req_a <= 1'b0;
			dbg <= 1'b0;
			rst_req <= 1'b0;
			pend <= 1'b0;
			$display("test stop case %0d done", i);
		end
		conclude();
	end
endmodule : tb
`default_nettype wire
